/* design/debug_link.sv */
// Purpose: device end of the one-pin background debug serial link
// Assumes: pin level is synchronous to ref_clk; host keeps its timing
// Notes:   byte level only; command framing sits above this block
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two-entry buffer
// ----------------------------------------------------------------
module fifo2 #(
    parameter int W = 8
) (
    input  wire logic         ref_clk, // clock
    input  wire logic         rst_b,   // async reset, active low
    input  wire logic [W-1:0] in_data, // write data
    input  wire logic         in_valid,// write request
    output logic              in_ready,// room for a word
    output logic [W-1:0]      out_data,// head word
    output logic              out_valid,// head present
    input  wire logic         out_ready // reader takes head
);
    logic [W-1:0] mem [2];
    logic         wp;
    logic         rp;
    logic [1:0]   count;
    wire          push = in_valid & in_ready;
    wire          pop  = out_valid & out_ready;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rp];

    // pointers and fill level
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wp    <= 1'b0;
            rp    <= 1'b0;
            count <= 2'h0;
        end else begin
            wp    <= wp ^ push;
            rp    <= rp ^ pop;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    // storage, no reset needed on data
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end
endmodule // fifo2

// ----------------------------------------------------------------
// link engine
// ----------------------------------------------------------------
module debug_link
    import debug_link_pkg::*;
(
    input  wire logic       ref_clk,     // 100 MHz clock
    input  wire logic       rst_b,       // async reset, active low
    input  wire logic       pin_in,      // debug_pin level
    output logic            pin_out,     // debug_pin drive level
    output logic            pin_oe,      // debug_pin driven when high
    output logic            pullup_en,   // weak pull-up enable
    output logic            special_mode,// mode caught after reset
    input  wire logic [7:0] tx_data,     // byte to return to host
    input  wire logic       tx_valid,    // tx byte offered
    output logic            tx_ready,    // tx byte accepted
    output logic [7:0]      rx_data,     // byte from host
    output logic            rx_valid,    // rx byte present
    input  wire logic       rx_ready,    // user takes rx byte
    output logic            timeout,     // transfer abandoned pulse
    output logic            overrun      // rx byte lost pulse
);
    link_state_e state;
    logic [2:0]  div_cnt;
    logic        pin_q;
    logic        mode_caught;
    logic [3:0]  tick_cnt;
    logic [2:0]  bit_idx;
    logic [7:0]  shift;
    logic        tx_loaded;
    logic        hi_at_glitch;
    logic [9:0]  idle_ticks;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // target tick every fifth ref_clk cycle
    wire tick      = (div_cnt == DIV_LAST);                    // R2
    // edge recognised at a tick, so up to one tick late
    wire fall      = tick & mode_caught & (state == ST_WAIT)
                     & pin_q & ~pin_in;                        // R3 R8
    wire in_bit    = (state == ST_BIT);
    wire tx_bit    = shift[7];                                 // R4
    wire at_sample = in_bit & tick & (tick_cnt == SAMPLE_TICK);
    wire at_glitch = in_bit & tick & (tick_cnt == GLITCH_TICK);
    wire at_end    = in_bit & tick & (tick_cnt == BIT_END_TICK);
    // a one must already be high at tick eight to count
    wire rx_bit    = pin_in & hi_at_glitch;                    // R9 R10
    wire byte_last = (bit_idx == LAST_BIT);
    wire rx_done   = at_sample & ~tx_loaded & byte_last;
    wire expired   = (idle_ticks == TIMEOUT_TICKS);            // R5
    wire buf_ready;
    // zero held low past the host sample point
    wire drive_lo  = in_bit & tx_loaded & ~tx_bit
                     & (tick_cnt < ZERO_SPD_TICK);             // R14
    wire spd_one   = tx_loaded & tx_bit & (tick_cnt == ONE_SPD_TICK);
    wire spd_zero  = tx_loaded & ~tx_bit & (tick_cnt == ZERO_SPD_TICK);
    wire speedup   = in_bit & (spd_one | spd_zero);            // R7 R12 R14

    assign pullup_en = 1'b1;                                   // R6
    // not while expiring: a byte taken then would be dropped unseen
    assign tx_ready  = mode_caught & ~tx_loaded & (state == ST_WAIT)
                       & ~expired;
    assign overrun   = rx_done & ~buf_ready;

    // ------------------------------------------------------------
    // target clock divider and pin history
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= 3'h0;
            pin_q   <= 1'b1;
        end else begin
            div_cnt <= tick ? 3'h0 : div_cnt + 3'h1;           // R2
            pin_q   <= tick ? pin_in : pin_q;
        end
    end

    // mode strap caught on the first edge after release; low = special
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_caught  <= 1'b0;
            special_mode <= 1'b0;
        end else if (!mode_caught) begin
            mode_caught  <= 1'b1;                              // R1
            special_mode <= ~pin_in;                           // R1
        end
    end

    // ------------------------------------------------------------
    // bit sequencer: starts at a host edge seen while waiting; edges inside a bit are ignored
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state    <= ST_WAIT;
            tick_cnt <= 4'h0;
        end else begin
            case (state)
                ST_WAIT: begin
                    if (fall) begin
                        state    <= ST_BIT;                    // R8
                        tick_cnt <= 4'h1;  // edge tick is tick 0
                    end
                end
                ST_BIT: begin
                    if (at_end) begin
                        state <= ST_WAIT;
                    end else if (tick) begin
                        tick_cnt <= tick_cnt + 4'h1;
                    end
                end
                default: state <= ST_WAIT;
            endcase
        end
    end

    // byte position, shifter, tx ownership and glitch sample
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_idx      <= 3'h0;
            shift        <= 8'h00;
            tx_loaded    <= 1'b0;
            hi_at_glitch <= 1'b0;
        end else if (expired) begin
            bit_idx   <= 3'h0;                                 // R5
            tx_loaded <= 1'b0;
        end else if (tx_valid & tx_ready) begin
            shift     <= tx_data;
            tx_loaded <= 1'b1;
        end else begin
            if (at_glitch) begin
                hi_at_glitch <= pin_in;                        // R10
            end
            if (at_sample & ~tx_loaded) begin
                shift <= {shift[6:0], rx_bit};                 // R4 R9
            end
            if (at_end) begin
                bit_idx <= bit_idx + 3'h1;
                if (tx_loaded) begin
                    shift <= {shift[6:0], 1'b0};               // R4
                end
                if (tx_loaded & byte_last) begin
                    tx_loaded <= 1'b0;
                end
            end
        end
    end

    // host silence counter, armed mid-byte or while a tx byte is loaded
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            idle_ticks <= 10'h000;
            timeout    <= 1'b0;
        end else begin
            timeout <= expired;
            if (fall || expired || (bit_idx == 3'h0 && !tx_loaded)) begin
                idle_ticks <= 10'h000;
            end else if (tick && state == ST_WAIT) begin
                idle_ticks <= idle_ticks + 10'h001;            // R5
            end
        end
    end

    // pin drive: low for a zero, short high pulse to speed the rise
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_oe  <= 1'b0;                                   // R1
            pin_out <= 1'b0;
        end else begin
            pin_oe  <= drive_lo | speedup;                     // R6
            pin_out <= speedup;                                // R7
        end
    end

    // ------------------------------------------------------------
    // receive buffer: a slow reader loses a byte only when two are already waiting
    // ------------------------------------------------------------
    fifo2 #(.W(8)) rx_buf (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .in_data  ({shift[6:0], rx_bit}),
        .in_valid (rx_done),
        .in_ready (buf_ready),
        .out_data (rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_start;
        fall;
    endsequence
    sequence s_sample_point;
        ##50 at_sample;
    endsequence

    tick_period_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        tick |=> !tick [*4] ##1 tick)                          // R2
        else $error("target tick not every fifth cycle");
    sample_ten_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_start |-> s_sample_point)                            // R9
        else $error("sample not ten ticks after start");
    glitch_before_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        at_glitch |-> ##10 at_sample)                          // R10
        else $error("glitch check not two ticks before sample");
    one_speedup_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (fall && tx_loaded && tx_bit) |-> ##36 (pin_oe && pin_out)) // R12
        else $error("one not answered by pulse at tick seven");
    zero_low_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (fall && tx_loaded && !tx_bit)
        |-> ##2 (pin_oe && !pin_out) [*8]
        ##41 (pin_oe && !pin_out))                             // R14
        else $error("zero not held low through sample");
    zero_release_a: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        (fall && tx_loaded && !tx_bit) |-> ##61 (pin_oe && pin_out)
        ##5 !pin_oe)                                           // R7
        else $error("zero not ended by speedup pulse");
    reset_release_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !mode_caught |-> !pin_oe && !fall)                     // R1
        else $error("pin used before mode was caught");
    timeout_abort_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        expired |=> timeout && bit_idx == 3'h0 && !tx_loaded)  // R5
        else $error("timeout did not abandon transfer");
    msb_first_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        rx_done && !rx_valid |=> rx_valid
        && rx_data[7] == $past(shift[6])
        && rx_data[0] == $past(rx_bit))                        // R4
        else $error("received byte not msb first");
    no_drive_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (state == ST_WAIT && $past(state) == ST_WAIT) |-> !pin_oe) // R6
        else $error("pin driven between bits");
endmodule // debug_link

/* common/debug_link_pkg.sv */
// Purpose: constants shared by the single-wire debug link
// Assumes: ref_clk at 100 MHz, one clock domain
// Notes:   counts below are in target clock ticks outside the clocking group
//
// Functional notes
// R1 - during reset the pin selects mode; afterwards it is only the link
// R2 - link timing comes from a target tick of the clock divided by five
// R3 - host starts every bit with a falling edge on the pin
// R4 - bytes go most significant bit first, sixteen target ticks per bit
// R5 - 512 target ticks without a host edge abandon the transfer
// R6 - pin is pseudo open drain with weak pull-up always on
// R7 - short driven-high speedup pulses restore the pin high
// R8 - edge seen up to one tick late; all delays measured from it
// R9 - received bit is sampled ten ticks after recognised start
// R10 - host drives high within eight ticks for a one, else rejected
// R11 - host holds pin low at least two ticks when reading
// R12 - device returns a one with speedup pulse at tick seven
// R13 - host samples returned bit about ten ticks after its edge
// R14 - device returns zero low past tick ten, then speedup before end
// R15 - host sending zero holds low past sample, then speedup pulse
package debug_link_pkg;
    // ------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------
    localparam int       REF_PERIOD_NS = 10;
    localparam logic [2:0] TGT_DIV     = 3'h5;
    localparam logic [2:0] DIV_LAST    = TGT_DIV - 3'h1;
    localparam int       TGT_PERIOD_NS = REF_PERIOD_NS * 5;
    // ------------------------------------------------------------
    // bit timing in target ticks from the recognised start
    // ------------------------------------------------------------
    localparam logic [3:0] ONE_SPD_TICK  = 4'h7;
    localparam logic [3:0] GLITCH_TICK   = 4'h8;
    localparam logic [3:0] SAMPLE_TICK   = 4'ha;
    localparam logic [3:0] ZERO_SPD_TICK = 4'hc;
    localparam logic [3:0] BIT_END_TICK  = 4'hd;
    localparam int         BIT_TICKS     = 16;
    localparam logic [9:0] TIMEOUT_TICKS = 10'h200;
    localparam logic [2:0] LAST_BIT      = 3'h7;
    // ------------------------------------------------------------
    // engine states
    // ------------------------------------------------------------
    typedef enum logic {
        ST_WAIT = 1'b0,
        ST_BIT  = 1'b1
    } link_state_e;
endpackage

/* testbench/debug_host.sv */
// Purpose: host adapter model that drives the shared debug pin
// Assumes: ref_clk at 100 MHz; one target tick is five ref_clk cycles
// Notes:   every bit slot is 80 cycles; the bench resolves the wire
`timescale 1ns/1ps
module debug_host (
    input  wire logic ref_clk,  // bench clock
    input  wire logic pin,      // resolved debug_pin level
    output logic      host_oe,  // host drives the pin when high
    output logic      host_out  // host drive level
);
    initial begin
        host_oe  = 1'b0;
        host_out = 1'b0;
    end

    // drive or release for n cycles; released leaves the pull-up in charge
    task automatic hold(input logic oe, input logic v, input int n);
        host_oe  <= oe;
        host_out <= v;
        repeat (n) @(posedge ref_clk);
    endtask

    // one written bit; a rise later than tick eight is a broken one
    task automatic send_bit(input logic b, input int rise);
        hold(1'b1, 1'b0, b ? rise : 60);
        hold(1'b1, 1'b1, 5);
        hold(1'b0, 1'b0, b ? 75 - rise : 15);
    endtask

    task automatic send_byte(input logic [7:0] d, input int rise);
        for (int i = 7; i >= 0; i--)
            send_bit(d[i], rise);
    endtask

    // short low start, then let go so the target can answer in time
    task automatic read_byte(output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            hold(1'b1, 1'b0, 10);
            hold(1'b0, 1'b0, 39);
            @(negedge ref_clk);
            d[i] = pin;
            @(posedge ref_clk);
            hold(1'b0, 1'b0, 30);
        end
    endtask
endmodule // debug_host

/* testbench/debug_link_bench.sv */
// Purpose: self-checking bench for the device end of the debug link
// Assumes: debug_host plays the far side; pull-up modelled in the wire
// Notes:   expected bytes and counts follow from the bit timing alone
`timescale 1ns/1ps
module debug_link_bench;
    logic       ref_clk;
    logic       rst_b    = 1'b0;
    logic       tx_valid = 1'b0;
    logic       rx_ready = 1'b0;
    logic [7:0] tx_data  = 8'h00;
    logic [7:0] rx_data, got;
    logic       pin_out, pin_oe, pullup_en, special_mode, tx_ready;
    logic       rx_valid, timeout, overrun, host_oe, host_out;
    wire        pin;
    int         failures = 0;
    int         checked  = 0;
    int         n_to     = 0;
    int         n_ovr    = 0;

    // device wins over host, released wire floats up to one
    assign pin = pin_oe ? pin_out : (host_oe ? host_out : 1'b1);

    debug_link u_dut (.ref_clk, .rst_b, .pin_in(pin), .pin_out, .pin_oe,
        .pullup_en, .special_mode, .tx_data, .tx_valid, .tx_ready,
        .rx_data, .rx_valid, .rx_ready, .timeout, .overrun);
    debug_host u_host (.ref_clk, .pin, .host_oe, .host_out);

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // one-cycle pulses are counted where they stand
    always @(posedge ref_clk) begin
        if (timeout === 1'b1) n_to++;
        if (overrun === 1'b1) n_ovr++;
    end

    task automatic report_and_stop;
        if (failures == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic check1(input logic seen, input logic exp);
        check({7'h00, seen}, {7'h00, exp});
    endtask

    // head must be present and equal, then it is popped
    task automatic pop_expect(input logic [7:0] exp);
        @(negedge ref_clk);
        check1(rx_valid, 1'b1);
        check(rx_data, exp);
        @(posedge ref_clk) rx_ready <= 1'b1;
        @(posedge ref_clk) rx_ready <= 1'b0;
    endtask

    task automatic t_tx(input logic [7:0] d);
        int i;
        @(posedge ref_clk) tx_data <= d;
        tx_valid <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(negedge ref_clk);
            if (tx_ready === 1'b1) break;
        end
        if (i == 100) begin
            failures++;
            report_and_stop();
        end
        @(posedge ref_clk) tx_valid <= 1'b0;
        u_host.read_byte(got);
        check(got, d);
        @(negedge ref_clk);
        check1(tx_ready, 1'b1);
    endtask

    // two bytes wait, the third finds the buffer full and is lost
    task automatic t_fill;
        int o;
        o = n_ovr;
        u_host.send_byte(8'h81, 20);
        u_host.send_byte(8'h7e, 20);
        u_host.send_byte(8'hc3, 20);
        check(8'(n_ovr - o), 8'h01);
        pop_expect(8'h81);
        pop_expect(8'h7e);
        @(negedge ref_clk);
        check1(rx_valid, 1'b0);
    endtask

    // idle never expires; a stalled byte expires near 512 ticks
    task automatic t_timeout;
        int o;
        o = n_to;
        u_host.hold(1'b0, 1'b0, 3000);
        check(8'(n_to - o), 8'h00);
        for (int i = 0; i < 3; i++)
            u_host.send_bit(1'b1, 20);
        u_host.hold(1'b0, 1'b0, 2300);
        check(8'(n_to - o), 8'h00);
        u_host.hold(1'b0, 1'b0, 400);
        check(8'(n_to - o), 8'h01);
        u_host.send_byte(8'h3c, 20);
        pop_expect(8'h3c);
    endtask

    // mid-run reset with the pin released: normal mode, buffer and
    // bit count cleared, so the next byte lines up from its first bit
    task automatic t_reset;
        u_host.send_byte(8'h96, 20);
        u_host.send_bit(1'b1, 20);
        @(posedge ref_clk) rst_b <= 1'b0;
        repeat (12) @(posedge ref_clk);
        check1(rx_valid, 1'b0);
        check1(pin_oe, 1'b0);
        rst_b <= 1'b1;
        u_host.hold(1'b0, 1'b0, 3);
        check1(special_mode, 1'b0);
        u_host.send_byte(8'h69, 20);
        pop_expect(8'h69);
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        failures++;
        report_and_stop();
    end

    initial begin
        u_host.hold(1'b1, 1'b0, 12);        // pin low across reset
        check1(pin_oe, 1'b0);
        check1(pullup_en, 1'b1);
        rst_b <= 1'b1;
        u_host.hold(1'b1, 1'b0, 3);
        check1(special_mode, 1'b1);
        u_host.hold(1'b0, 1'b0, 20);
        u_host.send_byte(8'ha5, 20);
        pop_expect(8'ha5);
        t_tx(8'h5a);
        t_tx(8'h81);
        u_host.send_byte(8'hff, 48);
        pop_expect(8'h00);
        t_fill();
        t_timeout();
        check1(special_mode, 1'b1);
        check1(pullup_en, 1'b1);
        t_reset();
        report_and_stop();
    end
endmodule // debug_link_bench
